//--- rtl/apcr_top.sv
// Purpose: processing-path and output/volume configuration registers and their effects
// Assumes: byte register port from the serial control decoder, same clock domain
// Notes:   channel index 2 is the subwoofer channel
`timescale 1ns/1ps
`default_nettype none
`include "apcr_regs.svh"

module apcr_top
   import apcr_pkg::*;
#(
   parameter logic [15:0] STD_POWER_COEF = 16'h0000,
   parameter int          ZERO_RUN_LEN   = `APCR_ZERO_RUN,
   parameter int          PWM_NORM_CYC   = `APCR_PWM_NORM_CYC,
   parameter int          PWM_ODD_CYC    = `APCR_PWM_ODD_CYC
) (
   // clock and reset
   input  wire logic               clock_in,
   input  wire logic               srst_in,
   // register port
   input  wire logic [7:0]         reg_addr_in,
   input  wire logic               reg_wr_in,
   input  wire logic [7:0]         reg_wdata_in,
   input  wire logic               reg_rd_in,
   output logic [7:0]              reg_rdata_out,
   output logic                    reg_rvalid_out,
   // decoded controls
   output apcr_ctrl_s              ctrl_out,
   // coefficient and post-scale selection
   input  wire logic [2:0][7:0]    postscale_in,
   output logic [2:0][7:0]         postscale_out,
   output logic [2:0][1:0]         coef_bank_out,
   // power correction
   input  wire logic [15:0]        power_corr_coef_in,
   output logic [15:0]             power_corr_coef_out,
   // pwm frame rate
   output logic                    pwm_frame_tick_out,
   // volume
   input  wire logic [2:0][7:0]    vol_target_in,
   input  wire logic [2:0]         vol_bypass_in,
   output logic [2:0][7:0]         vol_out,
   // sample path
   input  wire logic               sample_tick_in,
   input  wire apcr_sample_t [2:0] map_sample_in,
   input  wire apcr_sample_t [2:0] proc_sample_in,
   output apcr_sample_t [2:0]      pwm_sample_out,
   output logic                    pwm_sample_valid_out,
   output logic [2:0]              zero_mute_out
);

   // saturating add for the submix
   function automatic apcr_sample_t apcr_sat_add(input apcr_sample_t a,
                                                 input apcr_sample_t b);
      logic signed [24:0] t;
      begin
         t = {a[23], a} + {b[23], b};
         if (t[24] != t[23]) begin
            apcr_sat_add = t[24] ? 24'sh800000 : 24'sh7FFFFF;
         end else begin
            apcr_sat_add = t[23:0];
         end
      end
   endfunction : apcr_sat_add

   // post-scale: 8'hFF is unity, lower codes attenuate linearly
   function automatic apcr_sample_t apcr_scale(input apcr_sample_t s,
                                               input logic [7:0]   ps);
      logic signed [9:0]  f;
      logic signed [33:0] p;
      begin
         f          = $signed({2'b00, ps}) + 10'sh001;
         p          = s * f;
         apcr_scale = p[31:8];
      end
   endfunction : apcr_scale

   // register storage
   logic [7:0]   path_q;
   logic [7:0]   outvol_q;
   apcr_ctrl_s   ctrl_d;

   wire hit_path   = (reg_addr_in == `APCR_ADDR_PATH);
   wire hit_outvol = (reg_addr_in == `APCR_ADDR_OUTVOL);
   wire wr_path    = reg_wr_in && hit_path;
   wire wr_outvol  = reg_wr_in && hit_outvol;

   // unmapped addresses read as zero
   wire [7:0] rd_mux = hit_path   ? path_q :
                       hit_outvol ? (outvol_q & `APCR_WMASK_OUTVOL) :
                       8'h00;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         path_q         <= `APCR_RST_PATH;
         outvol_q       <= `APCR_RST_OUTVOL;
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         if (wr_path) begin
            path_q <= reg_wdata_in;
         end
         if (wr_outvol) begin
            outvol_q <= reg_wdata_in & `APCR_WMASK_OUTVOL;
         end
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
         end
      end
   end

   // control decode
   assign ctrl_d.hp_filter_en        = !path_q[`APCR_B_DC_BYP];
   assign ctrl_d.eq_mix_bypass       = path_q[`APCR_B_EQ_BYP];
   assign ctrl_d.deemph_active       = path_q[`APCR_B_DEEMPH] &&
                                       !path_q[`APCR_B_EQ_BYP];
   assign ctrl_d.postscale_link      = path_q[`APCR_B_PS_LINK];
   assign ctrl_d.coef_link           = path_q[`APCR_B_COEF_LINK];
   assign ctrl_d.compression_mode    = path_q[`APCR_B_COMPRESS];
   assign ctrl_d.zero_detect_mute_en = path_q[`APCR_B_ZD_MUTE];
   assign ctrl_d.submix_enable       = path_q[`APCR_B_SUBMIX] &&
                                       !path_q[`APCR_B_EQ_BYP];
   assign ctrl_d.power_corr_active   = outvol_q[`APCR_B_PC_EN];
   assign ctrl_d.power_corr_use_var  = outvol_q[`APCR_B_PC_EN] &&
                                       outvol_q[`APCR_B_PC_VAR];
   assign ctrl_d.am_noise_reduce     = outvol_q[`APCR_B_AM_RED];
   assign ctrl_d.pwm_speed_sel       = outvol_q[`APCR_B_PWM_SPD];
   assign ctrl_d.zero_cross_vol_en   = outvol_q[`APCR_B_ZC_VOL];
   assign ctrl_d.soft_volume_en      = outvol_q[`APCR_B_SOFT_VOL];

   // power correction coefficient; disabled correction drives zero
   wire [15:0] pc_coef_d = !ctrl_d.power_corr_active ? 16'h0000 :
                           ctrl_d.power_corr_use_var ? power_corr_coef_in :
                           STD_POWER_COEF;

   // per-channel post-scale and coefficient bank
   logic [2:0][7:0] ps_sel;
   logic [2:0][1:0] bank_sel;

   for (genvar ch = 0; ch < 3; ch++) begin : g_sel
      assign ps_sel[ch]   = ctrl_d.postscale_link ? postscale_in[0]
                                                  : postscale_in[ch];
      assign bank_sel[ch] = ctrl_d.coef_link ? 2'h0 : 2'(ch);
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl_out            <= '0;
         postscale_out       <= '0;
         coef_bank_out       <= '0;
         power_corr_coef_out <= 16'h0000;
      end else begin
         ctrl_out            <= ctrl_d;
         postscale_out       <= ps_sel;
         coef_bank_out       <= bank_sel;
         power_corr_coef_out <= pc_coef_d;
      end
   end

   // pwm frame divider; integer periods round the rates up slightly
   logic [9:0] pwm_cnt_q;
   wire  [9:0] pwm_last = ctrl_d.pwm_speed_sel ? 10'(PWM_ODD_CYC - 1)
                                               : 10'(PWM_NORM_CYC - 1);
   wire        pwm_wrap = (pwm_cnt_q >= pwm_last);

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pwm_cnt_q          <= 10'h000;
         pwm_frame_tick_out <= 1'b0;
      end else begin
         pwm_cnt_q          <= pwm_wrap ? 10'h000 : pwm_cnt_q + 10'h001;
         pwm_frame_tick_out <= pwm_wrap;
      end
   end

   // zero detect and volume update per channel
   logic [2:0] zmute;

   for (genvar ch = 0; ch < 3; ch++) begin : g_chan
      apcr_zero_detect #(
         .RUN_LEN        (ZERO_RUN_LEN)
      ) u_zero (
         .clock_in       (clock_in),
         .srst_in        (srst_in),
         .enable_in      (ctrl_d.zero_detect_mute_en),
         .sample_tick_in (sample_tick_in),
         .sample_in      (map_sample_in[ch]),
         .mute_out       (zmute[ch])
      );

      apcr_vol_update u_vol (
         .clock_in         (clock_in),
         .srst_in          (srst_in),
         .zero_cross_en_in (ctrl_d.zero_cross_vol_en),
         .soft_en_in       (ctrl_d.soft_volume_en),
         .vol_bypass_in    (vol_bypass_in[ch]),
         .sample_tick_in   (sample_tick_in),
         .sample_in        (map_sample_in[ch]),
         .target_in        (vol_target_in[ch]),
         .vol_out          (vol_out[ch])
      );
   end

   assign zero_mute_out = zmute;

   // sample path: source select, submix, post-scale, auto mute
   apcr_sample_t [2:0] src;
   apcr_sample_t [2:0] mixed;
   apcr_sample_t [2:0] scaled;

   for (genvar ch = 0; ch < 3; ch++) begin : g_path
      // bypass takes the mapped sample straight past EQ and mixing
      assign src[ch] = ctrl_d.eq_mix_bypass ? map_sample_in[ch]
                                            : proc_sample_in[ch];
      if (ch < 2) begin : g_lr
         assign mixed[ch] = ctrl_d.submix_enable ? apcr_sat_add(src[ch], src[2])
                                                 : src[ch];
      end else begin : g_sub
         assign mixed[ch] = src[ch];
      end
      // post-scale follows the submix, ahead of only the auto mute, so it bounds the modulation index
      assign scaled[ch] = zmute[ch] ? 24'sh000000
                                    : apcr_scale(mixed[ch], ps_sel[ch]);
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pwm_sample_out       <= '0;
         pwm_sample_valid_out <= 1'b0;
      end else begin
         pwm_sample_valid_out <= sample_tick_in;
         if (sample_tick_in) begin
            pwm_sample_out <= scaled;
         end
      end
   end

endmodule : apcr_top
`default_nettype wire

//--- common/apcr_regs.svh
// Purpose: register map and counts of the audio path config block
// Assumes: byte-wide register port from the serial control decoder
// Notes:   definitions only
`ifndef APCR_REGS_SVH
`define APCR_REGS_SVH

`define APCR_ADDR_PATH      8'h03
`define APCR_ADDR_OUTVOL    8'h04
`define APCR_RST_PATH       8'h40
`define APCR_RST_OUTVOL     8'hC2
`define APCR_WMASK_OUTVOL   8'hDB

`define APCR_B_DC_BYP       0
`define APCR_B_DEEMPH       1
`define APCR_B_EQ_BYP       2
`define APCR_B_PS_LINK      3
`define APCR_B_COEF_LINK    4
`define APCR_B_COMPRESS     5
`define APCR_B_ZD_MUTE      6
`define APCR_B_SUBMIX       7

`define APCR_B_PC_VAR       0
`define APCR_B_PC_EN        1
`define APCR_B_AM_RED       3
`define APCR_B_PWM_SPD      4
`define APCR_B_ZC_VOL       6
`define APCR_B_SOFT_VOL     7

`define APCR_ZERO_RUN       2048
`define APCR_CLK_KHZ        100000
`define APCR_PWM_NORM_DKHZ  3840
`define APCR_PWM_ODD_DKHZ   3413
`define APCR_PWM_NORM_CYC   ((`APCR_CLK_KHZ * 10) / `APCR_PWM_NORM_DKHZ)
`define APCR_PWM_ODD_CYC    ((`APCR_CLK_KHZ * 10) / `APCR_PWM_ODD_DKHZ)
`define APCR_SOFT_STEP      8'h01

`endif

//--- common/apcr_pkg.sv
// Purpose: shared types of the audio path config block
// Assumes: three processing channels, 24-bit samples
// Notes:   none
package apcr_pkg;

   typedef logic signed [23:0] apcr_sample_t;

   typedef struct packed {
      logic hp_filter_en;
      logic deemph_active;
      logic eq_mix_bypass;
      logic postscale_link;
      logic coef_link;
      logic compression_mode;
      logic zero_detect_mute_en;
      logic submix_enable;
      logic power_corr_active;
      logic power_corr_use_var;
      logic am_noise_reduce;
      logic pwm_speed_sel;
      logic zero_cross_vol_en;
      logic soft_volume_en;
   } apcr_ctrl_s;

   typedef enum logic [2:0] {
      APCR_VS_IDLE = 3'b001,
      APCR_VS_WAIT = 3'b010,
      APCR_VS_RAMP = 3'b100
   } apcr_vol_state_e;

endpackage : apcr_pkg

//--- rtl/apcr_zero_detect.sv
// Purpose: per-channel run-of-zeros auto mute
// Assumes: sample_tick_in marks one new mapped sample
// Notes:   counter saturates at the run length
`timescale 1ns/1ps
`default_nettype none
`include "apcr_regs.svh"

module apcr_zero_detect
   import apcr_pkg::*;
#(
   parameter int RUN_LEN = `APCR_ZERO_RUN
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         srst_in,
   // sample side
   input  wire logic         enable_in,
   input  wire logic         sample_tick_in,
   input  wire apcr_sample_t sample_in,
   // result
   output logic              mute_out
);

   logic [12:0] run_q;
   logic [12:0] run_d;
   wire         at_run   = (run_q == 13'(RUN_LEN));
   wire         is_zero  = (sample_in == 24'sh000000);

   // a nonzero sample or disable clears the run
   assign run_d = !enable_in ? 13'h0000 :
                  !sample_tick_in ? run_q :
                  !is_zero ? 13'h0000 :
                  at_run ? run_q : run_q + 13'h0001;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         run_q    <= 13'h0000;
         mute_out <= 1'b0;
      end else begin
         run_q    <= run_d;
         mute_out <= enable_in && (run_d == 13'(RUN_LEN));
      end
   end

endmodule : apcr_zero_detect
`default_nettype wire

//--- rtl/apcr_vol_update.sv
// Purpose: applies a channel's target volume immediately, at zero crossings or ramped
// Assumes: volume code 8'h00 loudest, 8'hFF mute; one step per sample tick, or per zero crossing when zero cross is on
// Notes:   a target change during a ramp simply redirects the ramp
`timescale 1ns/1ps
`default_nettype none
`include "apcr_regs.svh"

module apcr_vol_update
   import apcr_pkg::*;
(
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         srst_in,
   // controls
   input  wire logic         zero_cross_en_in,
   input  wire logic         soft_en_in,
   input  wire logic         vol_bypass_in,
   // sample side
   input  wire logic         sample_tick_in,
   input  wire apcr_sample_t sample_in,
   // volume
   input  wire logic [7:0]   target_in,
   output logic [7:0]        vol_out
);

   apcr_vol_state_e state_q;
   apcr_vol_state_e state_d;
   apcr_sample_t    prev_q;
   logic [7:0]      vol_d;

   wire soft_ok  = soft_en_in && !vol_bypass_in;
   wire crossing = sample_tick_in &&
                   ((sample_in[23] != prev_q[23]) || (sample_in == 24'sh000000));
   wire moment   = zero_cross_en_in ? crossing : sample_tick_in;
   wire differ   = (target_in != vol_out);
   wire [7:0] step = (target_in > vol_out) ? vol_out + `APCR_SOFT_STEP
                                           : vol_out - `APCR_SOFT_STEP;

   always_comb begin
      state_d = state_q;
      vol_d   = vol_out;
      case (state_q)
         APCR_VS_IDLE: begin
            if (differ && (zero_cross_en_in || soft_ok)) begin
               state_d = soft_ok && !zero_cross_en_in ? APCR_VS_RAMP : APCR_VS_WAIT;
            end else if (differ) begin
               vol_d = target_in;
            end
         end
         APCR_VS_WAIT: begin
            // zero cross off: idle applies
            if (!differ || !zero_cross_en_in) begin
               state_d = APCR_VS_IDLE;
            end else if (moment && soft_ok) begin
               state_d = APCR_VS_RAMP;
               vol_d   = step;
            end else if (moment) begin
               state_d = APCR_VS_IDLE;
               vol_d   = target_in;
            end
         end
         APCR_VS_RAMP: begin
            if (!differ || !soft_ok) begin
               state_d = APCR_VS_IDLE;
            end else if (moment) begin
               vol_d = step;
            end
         end
         default: begin
            state_d = APCR_VS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_q <= APCR_VS_IDLE;
         prev_q  <= 24'sh000000;
         vol_out <= 8'h00;
      end else begin
         state_q <= state_d;
         vol_out <= vol_d;
         if (sample_tick_in) begin
            prev_q <= sample_in;
         end
      end
   end

endmodule : apcr_vol_update
`default_nettype wire

//--- test/apcr_properties.sv
// Purpose: port-level checks of the config register block
// Assumes: one clock, sync reset
// Notes:   p3_q/p4_q lag a write like ctrl_out
`timescale 1ns/1ps
`default_nettype none
module apcr_properties
   import apcr_pkg::*;
#(
   parameter logic [15:0] STD_POWER_COEF = 16'h0000,
   parameter int          ZERO_RUN_LEN   = 2048,
   parameter int          PWM_NORM_CYC   = 260,
   parameter int          PWM_ODD_CYC    = 292
) (
   // clock and reset
   input wire logic               clock_in,
   input wire logic               srst_in,
   // register port
   input wire logic [7:0]         reg_addr_in,
   input wire logic               reg_wr_in,
   input wire logic [7:0]         reg_wdata_in,
   input wire logic               reg_rd_in,
   input wire logic [7:0]         reg_rdata_out,
   input wire logic               reg_rvalid_out,
   // controls and selections
   input wire apcr_ctrl_s         ctrl_out,
   input wire logic [2:0][7:0]    postscale_in,
   input wire logic [2:0][7:0]    postscale_out,
   input wire logic [2:0][1:0]    coef_bank_out,
   input wire logic [15:0]        power_corr_coef_in,
   input wire logic [15:0]        power_corr_coef_out,
   input wire logic               pwm_frame_tick_out,
   // volume
   input wire logic [2:0][7:0]    vol_target_in,
   input wire logic [2:0]         vol_bypass_in,
   input wire logic [2:0][7:0]    vol_out,
   // sample path
   input wire logic               sample_tick_in,
   input wire apcr_sample_t [2:0] map_sample_in,
   input wire apcr_sample_t [2:0] proc_sample_in,
   input wire apcr_sample_t [2:0] pwm_sample_out,
   input wire logic               pwm_sample_valid_out,
   input wire logic [2:0]         zero_mute_out
);
   logic [7:0]  sh3_q, sh4_q, p3_q, p4_q;
   logic [1:0]  up_q;
   logic [15:0] gap_q, zrun_q;
   logic        seen_q, mix_q, spd_q;
   // a speed change leaves its period unjudged
   wire         chg    = ctrl_out.pwm_speed_sel != spd_q;
   wire  [7:0]  rd_exp = (reg_addr_in == 8'h03) ? sh3_q :
                         (reg_addr_in == 8'h04) ? (sh4_q & 8'hDB) : 8'h00;
   wire  [7:0]  exp3   = {~p3_q[0], p3_q[1] & ~p3_q[2], p3_q[2], p3_q[3], p3_q[4], p3_q[5],
                          p3_q[6], p3_q[7] & ~p3_q[2]};
   wire  [5:0]  exp4   = {p4_q[1], p4_q[1] & p4_q[0], p4_q[3], p4_q[4], p4_q[6], p4_q[7]};

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         sh3_q  <= 8'h40;
         sh4_q  <= 8'hC2;
         p3_q   <= 8'h40;
         p4_q   <= 8'hC2;
         up_q   <= 2'h0;
         gap_q  <= 16'h0;
         zrun_q <= 16'h0;
         seen_q <= 1'b0;
         mix_q  <= 1'b0;
         spd_q  <= 1'b0;
      end else begin
         if (reg_wr_in && reg_addr_in == 8'h03) sh3_q <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == 8'h04) sh4_q <= reg_wdata_in;
         p3_q   <= sh3_q;
         p4_q   <= sh4_q;
         up_q   <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
         spd_q  <= ctrl_out.pwm_speed_sel;
         gap_q  <= pwm_frame_tick_out ? 16'h1 : gap_q + 16'h1;
         seen_q <= seen_q | pwm_frame_tick_out;
         mix_q  <= pwm_frame_tick_out ? chg : (mix_q | chg);
         if (sample_tick_in) zrun_q <= (map_sample_in[0] == 0) ? zrun_q + 16'h1 : 16'h0;
      end
   end

   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);

   read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered");
   read_value_a: assert property (reg_rd_in |=> reg_rdata_out == $past(rd_exp))
      else $error("read data wrong");
   path_decode_a: assert property (up_q != 0 |-> ctrl_out[13:6] == exp3)
      else $error("path decode wrong");
   outvol_decode_a: assert property (up_q != 0 |-> ctrl_out[5:0] == exp4)
      else $error("outvol decode wrong");
   scale_link_a: assert property (up_q > 1 && $stable(p3_q) |->
      postscale_out == (p3_q[3] ? {3{$past(postscale_in[0])}} : $past(postscale_in)))
      else $error("post-scale wrong");
   coef_link_a: assert property (up_q > 1 && $stable(p3_q) |->
      coef_bank_out == (p3_q[4] ? 6'h00 : 6'h24))
      else $error("coef bank wrong");
   power_coef_a: assert property (up_q > 1 && $stable(p4_q) |-> power_corr_coef_out ==
      (!p4_q[1] ? 16'h0000 : (p4_q[0] ? $past(power_corr_coef_in) : STD_POWER_COEF)))
      else $error("power coef wrong");
   pwm_period_a: assert property (pwm_frame_tick_out && seen_q && !mix_q && !chg |->
      gap_q == (ctrl_out.pwm_speed_sel ? PWM_ODD_CYC : PWM_NORM_CYC))
      else $error("pwm frame period wrong");
   sample_valid_a: assert property (up_q != 0 |-> pwm_sample_valid_out == $past(sample_tick_in))
      else $error("sample valid late");
   zero_clear_a: assert property (sample_tick_in && map_sample_in[0] != 0 |=> !zero_mute_out[0])
      else $error("mute not cleared");
   zero_run_a: assert property ($rose(zero_mute_out[0]) |-> zrun_q >= ZERO_RUN_LEN)
      else $error("mute too early");
   vol_jump_a: assert property (up_q == 2'h3 && sh4_q[7:6] == 2'b00 &&
      $past(sh4_q[7:6]) == 2'b00 |=> vol_out[0] == $past(vol_target_in[0]))
      else $error("volume jump missed");
endmodule : apcr_properties

bind apcr_top apcr_properties #(.STD_POWER_COEF(STD_POWER_COEF), .ZERO_RUN_LEN(ZERO_RUN_LEN),
   .PWM_NORM_CYC(PWM_NORM_CYC), .PWM_ODD_CYC(PWM_ODD_CYC)) apcr_properties_inst (
   .clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .ctrl_out(ctrl_out), .postscale_in(postscale_in),
   .postscale_out(postscale_out), .coef_bank_out(coef_bank_out),
   .power_corr_coef_in(power_corr_coef_in), .power_corr_coef_out(power_corr_coef_out),
   .pwm_frame_tick_out(pwm_frame_tick_out), .vol_target_in(vol_target_in),
   .vol_bypass_in(vol_bypass_in), .vol_out(vol_out), .sample_tick_in(sample_tick_in),
   .map_sample_in(map_sample_in), .proc_sample_in(proc_sample_in),
   .pwm_sample_out(pwm_sample_out), .pwm_sample_valid_out(pwm_sample_valid_out),
   .zero_mute_out(zero_mute_out));
`default_nettype wire

//--- test/audio_path_config_regs_test.sv
// Purpose: self-checking bench of the config register block
// Assumes: short zero run and pwm periods
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module audio_path_config_regs_test
   import apcr_pkg::*;
;
   localparam logic [15:0] STD = 16'h5A5A;
   logic               clock_in = 0, srst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic               sample_tick_in = 0, reg_rvalid_out, pwm_frame_tick_out;
   logic               pwm_sample_valid_out;
   logic [7:0]         reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, p3, p4, r;
   apcr_ctrl_s         ctrl_out;
   logic [2:0][7:0]    postscale_in = 0, postscale_out, vol_target_in = 0, vol_out;
   logic [2:0][1:0]    coef_bank_out;
   logic [15:0]        power_corr_coef_in = 0, power_corr_coef_out;
   logic [2:0]         vol_bypass_in = 0, zero_mute_out;
   apcr_sample_t [2:0] map_sample_in = 0, proc_sample_in = 0, pwm_sample_out;
   logic [31:0]        seed = 32'h88144F68;
   int                 n_mismatch = 0, n_compared = 0, n;

   always #5 clock_in = ~clock_in;

   apcr_top #(.STD_POWER_COEF(STD), .ZERO_RUN_LEN(8), .PWM_NORM_CYC(5), .PWM_ODD_CYC(7))
   apcr_top_inst (
      .clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .reg_rvalid_out(reg_rvalid_out), .ctrl_out(ctrl_out), .postscale_in(postscale_in),
      .postscale_out(postscale_out), .coef_bank_out(coef_bank_out),
      .power_corr_coef_in(power_corr_coef_in), .power_corr_coef_out(power_corr_coef_out),
      .pwm_frame_tick_out(pwm_frame_tick_out), .vol_target_in(vol_target_in),
      .vol_bypass_in(vol_bypass_in), .vol_out(vol_out), .sample_tick_in(sample_tick_in),
      .map_sample_in(map_sample_in), .proc_sample_in(proc_sample_in),
      .pwm_sample_out(pwm_sample_out), .pwm_sample_valid_out(pwm_sample_valid_out),
      .zero_mute_out(zero_mute_out));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic apcr_ctrl_s exp_ctrl(input logic [7:0] p, input logic [7:0] o);
      return '{~p[0], p[1] & ~p[2], p[2], p[3], p[4], p[5], p[6], p[7] & ~p[2],
               o[1], o[1] & o[0], o[3], o[4], o[6], o[7]};
   endfunction : exp_ctrl

   // bypass drops the submix too
   function automatic logic [31:0] exp_out(input int k);
      logic signed [25:0] a;
      logic signed [35:0] y;
      a = p3[2] ? map_sample_in[k] : proc_sample_in[k];
      if (k < 2 && p3[7] && !p3[2]) a = a + proc_sample_in[2];
      if (a > 26'sh7FFFFF) a = 26'sh7FFFFF;
      if (a < -26'sh800000) a = -26'sh800000;
      y = a * $signed({2'b00, postscale_in[p3[3] ? 0 : k]} + 10'd1);
      return {8'h00, 24'(y >>> 8)};
   endfunction : exp_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int c);
      repeat (c) @(negedge clock_in);
   endtask : step

   // one-cycle write strobe; no gap is left before the next write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1;
      step(1);
      reg_wr_in = 0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      reg_addr_in = a;
      reg_rd_in = 1;
      step(1);
      r = reg_rdata_out;
      check(reg_rvalid_out, 1);
      reg_rd_in = 0;
      step(1);
   endtask : rd

   task automatic tick();
      sample_tick_in = 1;
      step(1);
      check(pwm_sample_valid_out, 1);
      sample_tick_in = 0;
      step(1);
   endtask : tick

   // first pass finds a frame edge
   task automatic pwm(output int c);
      repeat (2) begin
         c = 0;
         do begin
            step(1);
            c++;
         end while (!pwm_frame_tick_out && c < 40);
      end
   endtask : pwm

   task automatic results();
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   initial begin
      step(8);
      srst_in = 0;
      rd(8'h03);
      check(r, 8'h40);
      rd(8'h04);
      check(r, 8'hC2);
      wr(8'h05, 8'hFF);
      rd(8'h05);
      check(r, 8'h00);
      check(ctrl_out, exp_ctrl(8'h40, 8'hC2));
      $display("reset values done");
      for (int i = 0; i < 24; i++) begin
         p3 = (i == 0) ? 8'hFF : 8'(rnd());
         p4 = (i == 0) ? 8'hFF : 8'(rnd());
         wr(8'h03, p3);
         rd(8'h03);
         check(r, p3);
         wr(8'h04, p4);
         rd(8'h04);
         check(r, p4 & 8'hDB);
         check(ctrl_out, exp_ctrl(p3, p4));
      end
      $display("decode done");
      for (int i = 0; i < 16; i++) begin
         p3 = (i == 0) ? 8'hDC : (i == 1) ? 8'hC0 : ((8'(rnd()) & 8'h9C) | 8'h40);
         wr(8'h03, p3);
         postscale_in = 24'(rnd());
         for (int k = 0; k < 3; k++) begin
            map_sample_in[k] = 24'(rnd()) | 24'h1;
            proc_sample_in[k] = (i == 1) ? 24'h7FFFFF : (24'(rnd()) | 24'h1);
         end
         step(1);
         tick();
         for (int k = 0; k < 3; k++) begin
            check(postscale_out[k], postscale_in[p3[3] ? 0 : k]);
            check(coef_bank_out[k], p3[4] ? 2'd0 : 2'(k));
            check($unsigned(pwm_sample_out[k]), exp_out(k));
         end
      end
      $display("sample path done");
      for (int k = 0; k < 4; k++) begin
         power_corr_coef_in = 16'(rnd());
         wr(8'h04, 8'hB8 | 8'(k));
         step(2);
         check(power_corr_coef_out, k[1] ? (k[0] ? power_corr_coef_in : STD) : 16'h0);
      end
      wr(8'h04, 8'h00);
      pwm(n);
      check(n, 5);
      wr(8'h04, 8'h10);
      pwm(n);
      check(n, 7);
      $display("power and pwm done");
      wr(8'h03, 8'h40);
      map_sample_in[0] = 0;
      repeat (7) tick();
      check(zero_mute_out, 3'b000);
      tick();
      check(zero_mute_out, 3'b001);
      map_sample_in[0] = 24'h1;
      tick();
      check(zero_mute_out, 3'b000);
      check(pwm_sample_out[0], 32'h0);
      wr(8'h03, 8'h00);
      map_sample_in[0] = 0;
      repeat (9) tick();
      check(zero_mute_out, 3'b000);
      $display("zero detect done");
      wr(8'h04, 8'h00);
      vol_target_in[0] = 8'h40;
      step(3);
      check(vol_out[0], 8'h40);
      wr(8'h04, 8'h80);
      step(2);
      vol_target_in[0] = 8'h44;
      step(2);
      repeat (2) tick();
      check(vol_out[0], 8'h42);
      repeat (3) tick();
      check(vol_out[0], 8'h44);
      vol_bypass_in[1] = 1;
      vol_target_in[1] = 8'h30;
      step(3);
      check(vol_out[1], 8'h30);
      wr(8'h04, 8'h40);
      map_sample_in[2] = 24'h100;
      proc_sample_in[2] = 24'h100;
      tick();
      vol_target_in[2] = 8'h20;
      step(2);
      repeat (2) tick();
      check(vol_out[2], 8'h00);
      map_sample_in[2] = -24'sh100;
      proc_sample_in[2] = -24'sh100;
      tick();
      check(vol_out[2], 8'h20);
      $display("volume update done");
      results();
   end

   // tests need under 2000 cycles
   initial begin
      step(20000);
      n_mismatch++;
      results();
   end
endmodule : audio_path_config_regs_test
`default_nettype wire
